// ==== hdl/dsr_pkg.sv ====
// Package for the diagnostic, ADC and CRC status register bank.
// Assumes a byte-wide register read port from the serial bus decoder.
package dsr_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] SUPPLY_ADC_RESULT_OFS = 8'h72;
   localparam logic [7:0] ADC_CONVERSION_RESULT_OFS = 8'h73;
   localparam logic [7:0] DIAG_FAULT_LOW_OFS = 8'h74;
   localparam logic [7:0] DIAG_FAULT_HIGH_OFS = 8'h75;
   localparam logic [7:0] EEPROM_CRC_REFERENCE_OFS = 8'h77;
   localparam logic [7:0] CONFIG_CRC_CALCULATED_OFS = 8'h78;
   // ************************************************************
   // Reset values and field layout
   // ************************************************************
   localparam logic [7:0] ADC_RESULT_RST = 8'h00;
   localparam logic [7:0] SUPPLY_ADC_RST = 8'h00;
   localparam logic [7:0] CONFIG_CRC_RST = 8'h00;
   localparam logic [11:0] DIAG_FAULT_RST = 12'h000;
   localparam logic [7:0] CRC_REF_RST_BASE = 8'hB3;
   localparam logic [7:0] CRC_REF_RST_ALT = 8'h09;
   localparam int DIAG_LOW_MSB = 7;
   localparam int DIAG_HIGH_MSB = 11;
   localparam int DIAG_HIGH_LSB = 8;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
endpackage : dsr_pkg

// ==== hdl/dsr_status_regs.sv ====
// Read-only status bank: ADC results, diagnostic faults, CRC values.
// Assumes a decoder issuing one-cycle read strobes and engine pulses.
`timescale 1ns/1ps
module dsr_status_regs #(
   parameter bit ALT_VARIANT = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Register read port
   input wire logic rd_en_in,
   input wire logic [7:0] rd_addr_in,
   output logic [7:0] rd_data_out,
   // ADC engine
   input wire logic adc_done_in,
   input wire logic [7:0] adc_result_in,
   input wire logic supply_done_in,
   input wire logic [7:0] supply_result_in,
   // Diagnostic engine
   input wire logic diag_start_in,
   input wire logic diag_done_in,
   input wire logic [11:0] diag_open_in,
   input wire logic [11:0] diag_short_in,
   input wire logic [11:0] diag_single_in,
   // CRC engine and EEPROM
   input wire logic crc_valid_in,
   input wire logic [7:0] crc_value_in,
   input wire logic crc_ref_load_in,
   input wire logic [7:0] crc_ref_in,
   // Status flags
   output logic conversion_complete_flag_out,
   output logic diag_complete_flag_out,
   output logic crc_mismatch_flag_out
);
   logic [7:0] supply_adc_reg;
   logic [7:0] adc_result_reg;
   logic [11:0] diag_fault_reg;
   logic [7:0] crc_ref_reg;
   logic [7:0] conf_crc_reg;
   logic conv_done_reg;
   logic diag_done_reg;
   logic crc_fail_reg;
   logic adc_read;

   // ************************************************************
   // Address decode
   // ************************************************************
   // One read strobe aimed at one offset; shared by logic and checks
   function automatic logic is_read(input logic en, input logic [7:0] addr,
      input logic [7:0] ofs);
      is_read = en && (addr == ofs);
   endfunction : is_read

   // ************************************************************
   // Result registers
   // ************************************************************
   // Supply result: cleared only to keep simulation free of X
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         supply_adc_reg <= dsr_pkg::SUPPLY_ADC_RST;
      end else if (supply_done_in) begin
         supply_adc_reg <= supply_result_in;
      end
   end

   // General result
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         adc_result_reg <= dsr_pkg::ADC_RESULT_RST;
      end else if (adc_done_in) begin
         adc_result_reg <= adc_result_in;
      end
   end

   // ************************************************************
   // Diagnostic faults
   // ************************************************************
   // A new run wipes old results; finish latches any fault type
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         diag_fault_reg <= dsr_pkg::DIAG_FAULT_RST;
      end else if (diag_done_in) begin
         diag_fault_reg <= diag_open_in | diag_short_in
            | diag_single_in;
      end else if (diag_start_in) begin
         diag_fault_reg <= dsr_pkg::DIAG_FAULT_RST;
      end
   end

   // Done flag drops on a new start so stale flags are not trusted
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         diag_done_reg <= 1'b0;
      end else if (diag_done_in) begin
         diag_done_reg <= 1'b1;
      end else if (diag_start_in) begin
         diag_done_reg <= 1'b0;
      end
   end

   // ************************************************************
   // CRC registers
   // ************************************************************
   // Reference default depends on device variant
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         crc_ref_reg <= ALT_VARIANT ? dsr_pkg::CRC_REF_RST_ALT
                                    : dsr_pkg::CRC_REF_RST_BASE;
      end else if (crc_ref_load_in) begin
         crc_ref_reg <= crc_ref_in;
      end
   end

   // Computed CRC refreshes on each configuration recompute
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         conf_crc_reg <= dsr_pkg::CONFIG_CRC_RST;
      end else if (crc_valid_in) begin
         conf_crc_reg <= crc_value_in;
      end
   end

   // Compare is registered one cycle after either side updates
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         crc_fail_reg <= 1'b0;
      end else begin
         crc_fail_reg <= (conf_crc_reg != crc_ref_reg);
      end
   end

   // ************************************************************
   // Conversion-complete flag and read port
   // ************************************************************
   // Only a read of the general result clears the flag
   assign adc_read = is_read(rd_en_in, rd_addr_in,
      dsr_pkg::ADC_CONVERSION_RESULT_OFS);

   // New result wins over a clearing read in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         conv_done_reg <= 1'b0;
      end else if (adc_done_in) begin
         conv_done_reg <= 1'b1;
      end else if (adc_read) begin
         conv_done_reg <= 1'b0;
      end
   end

   // Read data registered; reads alter no stored value but the conversion-complete flag
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rd_data_out <= dsr_pkg::UNMAPPED_DATA;
      end else if (rd_en_in) begin
         case (rd_addr_in)
            dsr_pkg::SUPPLY_ADC_RESULT_OFS: rd_data_out <= supply_adc_reg;
            dsr_pkg::ADC_CONVERSION_RESULT_OFS: rd_data_out <= adc_result_reg;
            dsr_pkg::DIAG_FAULT_LOW_OFS:
               rd_data_out <= diag_fault_reg[dsr_pkg::DIAG_LOW_MSB:0];
            dsr_pkg::DIAG_FAULT_HIGH_OFS:
               rd_data_out <= {4'h0, diag_fault_reg[dsr_pkg::DIAG_HIGH_MSB:
                  dsr_pkg::DIAG_HIGH_LSB]};
            dsr_pkg::EEPROM_CRC_REFERENCE_OFS: rd_data_out <= crc_ref_reg;
            dsr_pkg::CONFIG_CRC_CALCULATED_OFS: rd_data_out <= conf_crc_reg;
            default: rd_data_out <= dsr_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   // Flags leave straight from their flip-flops
   assign conversion_complete_flag_out = conv_done_reg;
   assign diag_complete_flag_out = diag_done_reg;
   assign crc_mismatch_flag_out = crc_fail_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_adc_done;
      adc_done_in;
   endsequence

   chk_conv_flag_set: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) s_adc_done |=> conversion_complete_flag_out)
      else $error("conversion flag not set");
   chk_conv_flag_clear: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (adc_read && !adc_done_in)
      |=> !conversion_complete_flag_out)
      else $error("conversion flag not cleared by read");
   // Read of the general result returns the stored value
   chk_adc_result_rd: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) adc_read
      |=> rd_data_out == $past(adc_result_reg))
      else $error("adc result read mismatch");
   // General result taken from the engine on its pulse
   chk_adc_load: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) adc_done_in
      |=> adc_result_reg == $past(adc_result_in))
      else $error("adc result not loaded");
   // Supply result taken from the engine on its pulse
   chk_supply_load: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) supply_done_in
      |=> supply_adc_reg == $past(supply_result_in))
      else $error("supply result not loaded");
   // Supply result read back unchanged
   chk_supply_read: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      is_read(rd_en_in, rd_addr_in, dsr_pkg::SUPPLY_ADC_RESULT_OFS)
      |=> rd_data_out == $past(supply_adc_reg))
      else $error("supply result read mismatch");
   // Low fault byte maps channel n to bit n
   chk_diag_low_read: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      is_read(rd_en_in, rd_addr_in, dsr_pkg::DIAG_FAULT_LOW_OFS)
      |=> rd_data_out == $past(diag_fault_reg[dsr_pkg::DIAG_LOW_MSB:0]))
      else $error("low fault byte mismatch");
   // High fault nibble maps channels 8 to 11
   chk_diag_high_read: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      is_read(rd_en_in, rd_addr_in, dsr_pkg::DIAG_FAULT_HIGH_OFS)
      |=> rd_data_out[3:0] == $past(diag_fault_reg[dsr_pkg::DIAG_HIGH_MSB:
      dsr_pkg::DIAG_HIGH_LSB]))
      else $error("high fault nibble mismatch");
   chk_diag_high_zero: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (rd_en_in
      && rd_addr_in == dsr_pkg::DIAG_FAULT_HIGH_OFS) |=> rd_data_out[7:4] == 4'h0)
      else $error("reserved fault bits not zero");
   chk_diag_fault_set: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) diag_done_in |=> diag_fault_reg
      == $past(diag_open_in | diag_short_in | diag_single_in))
      else $error("diagnostic flags wrong");
   chk_diag_done: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) diag_done_in |=> diag_complete_flag_out)
      else $error("diagnostic complete not set");
   // A new run without a finish wipes flags and done
   chk_diag_start_clear: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (diag_start_in && !diag_done_in)
      |=> (diag_fault_reg == dsr_pkg::DIAG_FAULT_RST
      && !diag_complete_flag_out))
      else $error("diagnostic start did not clear");
   // Between runs the done flag does not move
   chk_diag_done_hold: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (!diag_start_in && !diag_done_in)
      |=> $stable(diag_complete_flag_out))
      else $error("diagnostic complete moved");
   // Between runs the fault flags do not move
   chk_diag_fault_hold: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (!diag_start_in && !diag_done_in)
      |=> $stable(diag_fault_reg))
      else $error("fault flags moved");
   // Flag holds unless a result or a clearing read arrives
   chk_conv_flag_hold: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (!adc_done_in && !adc_read)
      |=> $stable(conversion_complete_flag_out))
      else $error("conversion flag moved");
   // A plain read leaves the result and CRC registers alone
   chk_read_no_change: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (rd_en_in && !supply_done_in && !adc_done_in
      && !crc_valid_in && !crc_ref_load_in)
      |=> ($stable(adc_result_reg) && $stable(supply_adc_reg)
      && $stable(crc_ref_reg) && $stable(conf_crc_reg)))
      else $error("read altered a register");
   // Reference read back unchanged
   chk_crc_ref_read: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      is_read(rd_en_in, rd_addr_in, dsr_pkg::EEPROM_CRC_REFERENCE_OFS)
      |=> rd_data_out == $past(crc_ref_reg))
      else $error("crc reference read mismatch");
   // Computed CRC taken on its valid pulse
   chk_conf_crc_load: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) crc_valid_in
      |=> conf_crc_reg == $past(crc_value_in))
      else $error("computed crc not loaded");
   // Computed CRC read back unchanged
   chk_conf_crc_read: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      is_read(rd_en_in, rd_addr_in, dsr_pkg::CONFIG_CRC_CALCULATED_OFS)
      |=> rd_data_out == $past(conf_crc_reg))
      else $error("computed crc read mismatch");
   // Differing values raise the mismatch flag a cycle later
   chk_mismatch_set: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (conf_crc_reg != crc_ref_reg)
      |=> crc_mismatch_flag_out)
      else $error("crc mismatch not flagged");
   // Equal values clear the mismatch flag a cycle later
   chk_mismatch_pass: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (conf_crc_reg == crc_ref_reg)
      |=> !crc_mismatch_flag_out)
      else $error("crc mismatch not cleared");
   // Flag two cycles after a new CRC reflects that CRC
   chk_crc_mismatch: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (crc_valid_in && !crc_ref_load_in) ##1 1'b1
      |=> crc_mismatch_flag_out
      == ($past(crc_value_in, 2) != $past(crc_ref_reg)))
      else $error("crc mismatch flag wrong");
   // Values one edge after a reset cycle; no look back before time zero
   chk_reset_values: assert property (@(posedge ref_clk_in)
      sys_rst_in |=> (diag_fault_reg == dsr_pkg::DIAG_FAULT_RST
      && adc_result_reg == dsr_pkg::ADC_RESULT_RST
      && !diag_complete_flag_out && !conversion_complete_flag_out))
      else $error("reset values wrong");
   // Reference default follows the variant
   chk_crc_ref_reset: assert property (@(posedge ref_clk_in)
      sys_rst_in |=> crc_ref_reg == (ALT_VARIANT ? dsr_pkg::CRC_REF_RST_ALT
      : dsr_pkg::CRC_REF_RST_BASE))
      else $error("crc reference default wrong");
endmodule : dsr_status_regs

// ==== verification/dsr_host_model.sv ====
// Host model: issues single reads on the status bank read port.
// Assumes the bank answers one cycle after the taking edge.
`timescale 1ns/1ps
module dsr_host_model (
   // Clock
   input wire logic ref_clk_in,
   // Read port towards the bank
   output logic rd_en_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in
);
   // ****
   // Read access
   // ****
   // Idle address is scrambled so a stale value is never reused
   initial begin
      rd_en_out = 1'b0;
      rd_addr_out = 8'hFF;
   end
   // Strobe for one edge, take the answer an edge later
   task automatic do_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk_in);
      rd_en_out <= 1'b1;
      rd_addr_out <= addr;
      @(posedge ref_clk_in);
      rd_en_out <= 1'b0;
      rd_addr_out <= ~addr;
      @(posedge ref_clk_in);
      data = rd_data_in;
   endtask : do_read
   // Reference reprogramming after settings change is up to caller
endmodule : dsr_host_model

// ==== verification/tb_top.sv ====
// Testbench for the status bank: host reads plus engine pulses.
// Assumes the host model and the bank share one 200 MHz clock.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic rd_en;
   logic [7:0] rd_addr, rd_data, adc_res = 8'h00, sup_res = 8'h00;
   logic [7:0] crc_val = 8'h00, crc_ref = 8'h00;
   logic adc_done = 1'b0, sup_done = 1'b0, crc_valid = 1'b0;
   logic ref_load = 1'b0, d_start = 1'b0, d_done = 1'b0;
   logic [11:0] d_open = 12'h000, d_short = 12'h000, d_single = 12'h000;
   logic conv_flag, diag_flag, crc_flag;
   logic [7:0] alt_data;
   int mismatches = 0;
   int n_checks = 0;
   // Clock, 5 ns period
   always #2.5 ref_clk_in = ~ref_clk_in;
   dsr_host_model host (.ref_clk_in(ref_clk_in), .rd_en_out(rd_en),
      .rd_addr_out(rd_addr), .rd_data_in(rd_data));
   dsr_status_regs DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .rd_en_in(rd_en), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
      .adc_done_in(adc_done), .adc_result_in(adc_res),
      .supply_done_in(sup_done), .supply_result_in(sup_res),
      .diag_start_in(d_start), .diag_done_in(d_done),
      .diag_open_in(d_open), .diag_short_in(d_short),
      .diag_single_in(d_single), .crc_valid_in(crc_valid),
      .crc_value_in(crc_val), .crc_ref_load_in(ref_load),
      .crc_ref_in(crc_ref), .conversion_complete_flag_out(conv_flag),
      .diag_complete_flag_out(diag_flag), .crc_mismatch_flag_out(crc_flag));
   // Second variant shares every input; only its read data is compared
   dsr_status_regs #(.ALT_VARIANT(1'b1)) DUT_ALT (.ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
      .rd_data_out(alt_data), .adc_done_in(adc_done),
      .adc_result_in(adc_res), .supply_done_in(sup_done),
      .supply_result_in(sup_res), .diag_start_in(d_start),
      .diag_done_in(d_done), .diag_open_in(d_open),
      .diag_short_in(d_short), .diag_single_in(d_single),
      .crc_valid_in(crc_valid), .crc_value_in(crc_val),
      .crc_ref_load_in(ref_load), .crc_ref_in(crc_ref),
      .conversion_complete_flag_out(), .diag_complete_flag_out(),
      .crc_mismatch_flag_out());
   // ****
   // Helpers
   // ****
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      host.do_read(addr, d);
      check(d, exp);
   endtask : rd_check
   // Flags as {conversion, diagnostic, mismatch}; wait past edge updates
   task automatic flags(input logic [2:0] exp);
      #1;
      check({5'h00, conv_flag, diag_flag, crc_flag}, {5'h00, exp});
   endtask : flags
   task automatic diag_run(input logic [11:0] o, input logic [11:0] s,
      input logic [11:0] g);
      @(posedge ref_clk_in);
      d_start <= 1'b1;
      @(posedge ref_clk_in);
      d_start <= 1'b0;
      d_open <= o;
      d_short <= s;
      d_single <= g;
      flags(3'b001);
      @(posedge ref_clk_in);
      d_done <= 1'b1;
      @(posedge ref_clk_in);
      d_done <= 1'b0;
      flags(3'b011);
   endtask : diag_run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // Hang guard
   initial begin
      repeat (2000) @(posedge ref_clk_in);
      mismatches++;
      end_of_test;
   end
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (3) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd_check(8'h73, 8'h00);
      rd_check(8'h74, 8'h00);
      rd_check(8'h75, 8'h00);
      rd_check(8'h77, 8'hB3);
      check(alt_data, 8'h09);
      flags(3'b001);
      // Result data is removed after the pulse so only the pulse counts
      @(posedge ref_clk_in);
      adc_done <= 1'b1;
      adc_res <= 8'h5A;
      sup_done <= 1'b1;
      sup_res <= 8'hA5;
      @(posedge ref_clk_in);
      adc_done <= 1'b0;
      adc_res <= 8'h00;
      sup_done <= 1'b0;
      sup_res <= 8'h00;
      flags(3'b101);
      rd_check(8'h72, 8'hA5);
      flags(3'b101);
      rd_check(8'h73, 8'h5A);
      flags(3'b001);
      diag_run(12'h001, 12'h800, 12'h180);
      rd_check(8'h74, 8'h81);
      rd_check(8'h75, 8'h09);
      diag_run(12'h000, 12'h000, 12'h000);
      rd_check(8'h74, 8'h00);
      rd_check(8'h75, 8'h00);
      @(posedge ref_clk_in);
      crc_valid <= 1'b1;
      crc_val <= 8'hB3;
      @(posedge ref_clk_in);
      crc_valid <= 1'b0;
      crc_val <= 8'h00;
      @(posedge ref_clk_in);
      flags(3'b010);
      rd_check(8'h78, 8'hB3);
      @(posedge ref_clk_in);
      ref_load <= 1'b1;
      crc_ref <= 8'h5C;
      @(posedge ref_clk_in);
      ref_load <= 1'b0;
      crc_ref <= 8'h00;
      @(posedge ref_clk_in);
      flags(3'b011);
      rd_check(8'h77, 8'h5C);
      end_of_test;
   end
endmodule : tb_top
